/* rtl/disk_security_command_handler.sv */
// Security command handler: erase unit, freeze lock and set password.
`timescale 1ns/1ns
module disk_security_command_handler (
  input wire logic clk,
  input wire logic rst,
  input wire logic hard_reset,
  input wire logic nv_format,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic cmd_ready,
  input wire logic data_valid,
  input wire logic [15:0] data_word,
  output logic data_ready,
  output logic done,
  output logic abort_err,
  output logic status_err,
  output logic locked,
  output logic lock_enabled,
  output logic level_max,
  output logic frozen,
  output logic [15:0] rev_code,
  input wire logic [sec_pkg::LBA_W-1:0] native_max_lba,
  input wire logic zero_wr_ready,
  output logic zero_wr_valid,
  output logic [sec_pkg::LBA_W-1:0] zero_wr_lba
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_CMP,
    ST_END,
    ST_ERASE
  } state_t;

  typedef struct packed {
    state_t st;
    logic ready;
    logic dready;
    logic op_erase;
    logic sel_master;
    logic lvl_new;
    logic [7:0] idx;
    logic [15:0] hold;
    logic mismatch;
    logic [15:0] rev_new;
    logic start;
    logic done;
    logic abort;
    logic prep;
    logic frozen;
    logic locked;
    logic lock_en;
    logic level_max;
    logic [15:0] rev;
  } regs_t;

  regs_t q;
  regs_t d;

  logic acc;
  logic wacc;
  logic is_pw;
  logic fin;
  logic fail;
  logic [7:0] pw_off;
  logic pw_wr;
  logic [sec_pkg::PW_AW-1:0] pw_addr;
  logic [15:0] pw_rd;
  logic sweep_done;

  assign acc = cmd_valid && q.ready;
  assign wacc = data_valid && q.dready;
  assign is_pw = (q.idx >= sec_pkg::PW_FIRST) && (q.idx <= sec_pkg::PW_LAST);
  assign pw_off = q.idx - sec_pkg::PW_FIRST;
  // The selector picks which half of the store is read or written.
  assign pw_addr = {q.sel_master, pw_off[3:0]};
  assign pw_wr = wacc && is_pw && !q.op_erase;

  pw_store u_store (
    .clk(clk),
    .wr_en(pw_wr),
    .wr_addr(pw_addr),
    .wr_data(data_word),
    .rd_addr(pw_addr),
    .rd_data(pw_rd)
  );

  zero_sweep u_sweep (
    .clk(clk),
    .rst(rst),
    .start(q.start),
    .max_lba(native_max_lba),
    .wr_ready(zero_wr_ready),
    .wr_valid(zero_wr_valid),
    .wr_lba(zero_wr_lba),
    .done(sweep_done)
  );

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.start = 1'b0;
    fin = 1'b0;
    fail = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (acc) begin
          d.abort = 1'b0;
          // Any command other than prepare breaks the prepare chain.
          d.prep = 1'b0;
          d.idx = sec_pkg::CTRL_WORD;
          d.mismatch = 1'b0;
          d.rev_new = q.rev;
          case (cmd_code)
            sec_pkg::CMD_ERASE_PREP: begin
              d.prep = 1'b1;
              fin = 1'b1;
            end
            sec_pkg::CMD_FREEZE: begin
              d.frozen = 1'b1;
              fin = 1'b1;
            end
            sec_pkg::CMD_SET_PW: begin
              if (q.frozen) begin
                fin = 1'b1;
                fail = 1'b1;
              end else begin
                d.st = ST_RX;
                d.op_erase = 1'b0;
              end
            end
            sec_pkg::CMD_ERASE: begin
              if (q.frozen || !q.prep) begin
                fin = 1'b1;
                fail = 1'b1;
              end else begin
                d.st = ST_RX;
                d.op_erase = 1'b1;
              end
            end
            sec_pkg::CMD_UNLOCK, sec_pkg::CMD_DISABLE_PW: begin
              fin = 1'b1;
              fail = q.frozen;
            end
            default: begin
              fin = 1'b1;
              fail = 1'b1;
            end
          endcase
        end
      end
      ST_RX: begin
        if (wacc) begin
          d.hold = data_word;
          d.idx = q.idx + 8'h01;
          if (q.idx == sec_pkg::CTRL_WORD) begin
            d.sel_master = data_word[sec_pkg::SEL_BIT];
            d.lvl_new = data_word[sec_pkg::LEVEL_BIT];
          end
          // With locking off the erase never looks at the stored words.
          if (is_pw && q.op_erase && q.lock_en) begin
            d.st = ST_CMP;
          end
          if (q.idx == sec_pkg::REV_WORD && !q.op_erase) begin
            d.rev_new = data_word;
          end
          if (q.idx == sec_pkg::LAST_WORD) begin
            d.st = ST_END;
          end
        end
      end
      ST_CMP: begin
        // Every bit of every password word counts; no padding rule.
        d.mismatch = q.mismatch | (pw_rd != q.hold);
        d.st = ST_RX;
      end
      ST_END: begin
        if (q.op_erase) begin
          if (q.mismatch) begin
            fin = 1'b1;
            fail = 1'b1;
          end else begin
            d.start = 1'b1;
            d.st = ST_ERASE;
          end
        end else begin
          fin = 1'b1;
          if (q.sel_master) begin
            // A master password leaves locking alone at either level.
            if (q.rev_new <= sec_pkg::REV_MAX_VALID) begin
              d.rev = q.rev_new;
            end
          end else begin
            // Armed only; the locked flag moves at the next reset.
            d.lock_en = 1'b1;
            d.level_max = q.lvl_new;
          end
        end
      end
      ST_ERASE: begin
        if (sweep_done) begin
          // The master half of the store is left as it is.
          d.lock_en = 1'b0;
          d.locked = 1'b0;
          fin = 1'b1;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    if (fin) begin
      d.done = 1'b1;
      d.abort = fail;
      d.st = ST_IDLE;
    end
    if (hard_reset || rst) begin
      d.st = ST_IDLE;
      d.done = 1'b0;
      d.abort = 1'b0;
      d.prep = 1'b0;
      d.start = 1'b0;
      d.locked = q.lock_en;
    end
    // Frozen survives hard reset; only power-on clears it.
    if (rst) begin
      d.frozen = 1'b0;
    end
    // Non-volatile fields change only by command or factory format.
    if (nv_format) begin
      d.lock_en = 1'b0;
      d.level_max = 1'b0;
      d.rev = sec_pkg::REV_DEFAULT;
      d.locked = 1'b0;
    end
    d.ready = (d.st == ST_IDLE);
    d.dready = (d.st == ST_RX);
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign cmd_ready = q.ready;
  assign data_ready = q.dready;
  assign done = q.done;
  assign abort_err = q.abort;
  assign status_err = q.abort;
  assign locked = q.locked;
  assign lock_enabled = q.lock_en;
  assign level_max = q.level_max;
  assign frozen = q.frozen;
  assign rev_code = q.rev;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || hard_reset || nv_format);

  sequence freeze_cmd;
    acc && cmd_code == sec_pkg::CMD_FREEZE;
  endsequence
  sequence erase_no_prep;
    acc && cmd_code == sec_pkg::CMD_ERASE && !q.prep;
  endsequence
  sequence frozen_guarded;
    acc && q.frozen &&
      (cmd_code == sec_pkg::CMD_SET_PW || cmd_code == sec_pkg::CMD_ERASE);
  endsequence
  sequence user_set_end;
    q.st == ST_END && !q.op_erase && !q.sel_master;
  endsequence

  freeze_enter_a: assert property (freeze_cmd |=> frozen && done)
    else $error("freeze command did not freeze");
  frozen_hold_a: assert property (frozen |=> frozen)
    else $error("frozen state released without power-on");
  frozen_reject_a: assert property (frozen_guarded |=> done && abort_err)
    else $error("frozen device accepted a security change");
  prep_needed_a: assert property (erase_no_prep |=> done && abort_err)
    else $error("erase without prepare not aborted");
  erase_mismatch_a: assert property (
    q.st == ST_END && q.op_erase && q.mismatch |=> done && abort_err)
    else $error("erase with wrong password not aborted");
  lock_deferred_a: assert property (
    user_set_end |=> lock_enabled && $stable(locked))
    else $error("user password locked at once or not armed");
  master_nolock_a: assert property (
    q.st == ST_END && !q.op_erase && q.sel_master |=> $stable(lock_enabled))
    else $error("master password changed lock enable");
  skip_compare_a: assert property (
    q.st == ST_RX && q.op_erase && !q.lock_en |=> q.st != ST_CMP)
    else $error("erase compared password with locking off");
  erase_unlock_a: assert property (
    q.st == ST_ERASE && sweep_done |=> !lock_enabled && !locked && done &&
      !abort_err)
    else $error("erase end did not disable locking");
  rev_legal_a: assert property (rev_code != sec_pkg::REV_RESERVED)
    else $error("reserved revision code stored");
  abort_flags_a: assert property ($rose(abort_err) |-> done && status_err)
    else $error("abort raised outside completion or without status error");
endmodule

/* rtl/pw_store.sv */
// Non-volatile password store with a registered read port.
`timescale 1ns/1ns
module pw_store (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [sec_pkg::PW_AW-1:0] wr_addr,
  input wire logic [sec_pkg::WORD_W-1:0] wr_data,
  input wire logic [sec_pkg::PW_AW-1:0] rd_addr,
  output logic [sec_pkg::WORD_W-1:0] rd_data
);
  // No reset here: the contents model flash and must survive every reset.
  logic [sec_pkg::WORD_W-1:0] mem [sec_pkg::PW_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* rtl/sec_pkg.sv */
// Shared constants for the disk security command handler.
package sec_pkg;
  // Command codes seen on the task-file command register.
  localparam logic [7:0] CMD_SET_PW = 8'hF1;
  localparam logic [7:0] CMD_UNLOCK = 8'hF2;
  localparam logic [7:0] CMD_ERASE_PREP = 8'hF3;
  localparam logic [7:0] CMD_ERASE = 8'hF4;
  localparam logic [7:0] CMD_FREEZE = 8'hF5;
  localparam logic [7:0] CMD_DISABLE_PW = 8'hF6;

  // Parameter sector layout, in 16-bit words.
  localparam int SEL_BIT = 0;
  localparam int LEVEL_BIT = 8;
  localparam logic [7:0] CTRL_WORD = 8'h00;
  localparam logic [7:0] PW_FIRST = 8'h01;
  localparam logic [7:0] PW_LAST = 8'h10;
  localparam logic [7:0] REV_WORD = 8'h11;
  localparam logic [7:0] LAST_WORD = 8'hFF;

  // Master password revision codes.
  localparam logic [15:0] REV_DEFAULT = 16'hFFFE;
  localparam logic [15:0] REV_MAX_VALID = 16'hFFFD;
  localparam logic [15:0] REV_RESERVED = 16'hFFFF;

  // Password store: two passwords of sixteen words each.
  localparam int PW_AW = 5;
  localparam int PW_DEPTH = 32;
  localparam int WORD_W = 16;

  // Media addressing for the zero sweep.
  localparam int LBA_W = 28;
  localparam logic [27:0] LBA_ZERO = 28'h0000000;
  localparam logic [27:0] LBA_STEP = 28'h0000001;
endpackage

/* rtl/zero_sweep.sv */
// Walks every sector from address zero to the native maximum, writing zeros.
`timescale 1ns/1ns
module zero_sweep (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [sec_pkg::LBA_W-1:0] max_lba,
  input wire logic wr_ready,
  output logic wr_valid,
  output logic [sec_pkg::LBA_W-1:0] wr_lba,
  output logic done
);
  typedef struct packed {
    logic busy;
    logic [sec_pkg::LBA_W-1:0] lba;
    logic done;
  } sweep_t;

  sweep_t q;
  sweep_t d;

  // Writes only; nothing is read back and no defect record is touched.
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (start && !q.busy) begin
      d.busy = 1'b1;
      d.lba = sec_pkg::LBA_ZERO;
    end else if (q.busy && wr_ready) begin
      if (q.lba == max_lba) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.lba = q.lba + sec_pkg::LBA_STEP;
      end
    end
    if (rst) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign wr_valid = q.busy;
  assign wr_lba = q.lba;
  assign done = q.done;

  sweep_first_a: assert property (@(posedge clk) disable iff (rst)
    start && !q.busy |=> wr_valid && wr_lba == sec_pkg::LBA_ZERO)
    else $error("sweep does not begin at address zero");
  sweep_last_a: assert property (@(posedge clk) disable iff (rst)
    wr_valid && wr_ready && wr_lba == max_lba |=> done && !wr_valid)
    else $error("sweep does not stop at the native maximum");
endmodule

/* testbench/host_model.sv */
// Host controller model that issues security commands and parameter sectors.
`timescale 1ns/1ns
module host_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  input wire logic cmd_ready,
  output logic data_valid,
  output logic [15:0] data_word,
  input wire logic data_ready,
  input wire logic done,
  input wire logic abort_err
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    data_valid = 1'b0;
    data_word = 16'h0000;
  end

  // A nonzero bad index flips one bit of that password word.
  function automatic logic [15:0] word(input int i, input logic [15:0] ctrl,
      input logic [15:0] key, input logic [15:0] rev, input int bad);
    if (i == 0)
      return ctrl;
    if (i <= 16)
      return key ^ 16'(i) ^ ((i == bad) ? 16'h8000 : 16'h0000);
    if (i == 17)
      return rev;
    return 16'h5A5A ^ 16'(i);
  endfunction

  task automatic run(input logic [7:0] code, input bit sec,
      input logic [15:0] ctrl, input logic [15:0] key,
      input logic [15:0] rev, input int bad, output logic ab, output bit to);
    int n;
    n = 0;
    @(posedge clk);
    #1 cmd_valid = 1'b1;
    cmd_code = code;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    #1 cmd_valid = 1'b0;
    cmd_code = ~code;
    // The whole sector goes out even when the device will refuse it.
    for (int i = 0; sec && i < 256; i++) begin
      data_valid = 1'b1;
      data_word = word(i, ctrl, key, rev, bad);
      do begin
        @(posedge clk);
        n++;
      end while (data_ready !== 1'b1 && n < 3000);
      #1;
    end
    data_valid = 1'b0;
    data_word = ~data_word;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    ab = abort_err;
    to = (n >= 3000);
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the disk security command handler.
`timescale 1ns/1ns
module tb;
  localparam logic [27:0] NMAX = 28'h0000007;
  logic clk, rst, hard_reset, nv_format, cmd_valid, cmd_ready, data_valid;
  logic data_ready, done, abort_err, status_err, locked, lock_enabled;
  logic level_max, frozen, zero_wr_ready, zero_wr_valid;
  logic [7:0] cmd_code;
  logic [15:0] data_word, rev_code;
  logic [27:0] zero_wr_lba;
  int fail_count = 0;
  int cmp_count = 0;
  int exp_lba = 0;

  disk_security_command_handler i_disk_security_command_handler (
    .clk(clk), .rst(rst), .hard_reset(hard_reset), .nv_format(nv_format),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
    .data_valid(data_valid), .data_word(data_word),
    .data_ready(data_ready), .done(done), .abort_err(abort_err),
    .status_err(status_err), .locked(locked), .lock_enabled(lock_enabled),
    .level_max(level_max), .frozen(frozen), .rev_code(rev_code),
    .native_max_lba(NMAX), .zero_wr_ready(zero_wr_ready),
    .zero_wr_valid(zero_wr_valid), .zero_wr_lba(zero_wr_lba));

  host_model i_host_model (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_ready(cmd_ready), .data_valid(data_valid), .data_word(data_word),
    .data_ready(data_ready), .done(done), .abort_err(abort_err));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [27:0] e,
      input logic [27:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic final_report;
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // The media stalls every other cycle so the sweep must hold its address.
  initial zero_wr_ready = 1'b0;
  always @(posedge clk) begin
    if (zero_wr_valid === 1'b1 && zero_wr_ready) begin
      chk("zero_wr_lba", 28'(exp_lba), zero_wr_lba);
      exp_lba++;
    end
    #1 zero_wr_ready = ~zero_wr_ready;
  end

  task automatic cmd(input logic [7:0] c, input bit s, input logic [15:0] ctl,
      input logic [15:0] key, input logic [15:0] rev, input int bad,
      input logic ea);
    logic ab;
    bit to;
    i_host_model.run(c, s, ctl, key, rev, bad, ab, to);
    if (to) begin
      fail_count++;
      final_report();
    end
    chk("abort_err", 28'(ea), 28'(ab));
    chk("status_err", 28'(ea), 28'(status_err));
    chk("cmd_ready", 28'h1, 28'(cmd_ready));
    chk("data_ready", 28'h0, 28'(data_ready));
  endtask

  task automatic simple(input logic [7:0] c, input logic ea);
    cmd(c, 1'b0, 16'h0000, 16'h0000, 16'h0000, 0, ea);
  endtask

  task automatic erase(input logic [15:0] ctl, input logic [15:0] key,
      input int bad, input logic ea);
    simple(sec_pkg::CMD_ERASE_PREP, 1'b0);
    exp_lba = 0;
    cmd(sec_pkg::CMD_ERASE, 1'b1, ctl, key, 16'h0000, bad, ea);
    chk("sweep_len", ea ? 28'h0 : NMAX + 28'h1, 28'(exp_lba));
    if (!ea) begin
      chk("lock_enabled", 28'h0, 28'(lock_enabled));
      chk("locked", 28'h0, 28'(locked));
    end
  endtask

  task automatic pulse_hard_reset;
    @(posedge clk);
    #1 hard_reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 hard_reset = 1'b0;
  endtask

  task automatic t_set_master;
    chk("rev_code", 28'hFFFE, 28'(rev_code));
    cmd(8'hF1, 1'b1, 16'h0001, 16'hA000, 16'h1234, 0, 1'b0);
    chk("rev_code", 28'h1234, 28'(rev_code));
    chk("lock_enabled", 28'h0, 28'(lock_enabled));
    cmd(8'hF1, 1'b1, 16'h0101, 16'hA000, 16'hFFFF, 0, 1'b0);
    chk("rev_code", 28'h1234, 28'(rev_code));
    chk("lock_enabled", 28'h0, 28'(lock_enabled));
  endtask

  task automatic t_set_user_max;
    cmd(8'hF1, 1'b1, 16'h0100, 16'hB000, 16'h4321, 0, 1'b0);
    chk("lock_enabled", 28'h1, 28'(lock_enabled));
    chk("level_max", 28'h1, 28'(level_max));
    chk("locked", 28'h0, 28'(locked));
    chk("rev_code", 28'h1234, 28'(rev_code));
    pulse_hard_reset();
    chk("locked", 28'h1, 28'(locked));
  endtask

  task automatic t_erase_refused;
    simple(sec_pkg::CMD_ERASE, 1'b1);
    erase(16'h0000, 16'hB000, 16, 1'b1);
    erase(16'h0001, 16'hB000, 0, 1'b1);
    simple(sec_pkg::CMD_DISABLE_PW, 1'b0);
    simple(8'hEE, 1'b1);
    simple(sec_pkg::CMD_ERASE_PREP, 1'b0);
    simple(sec_pkg::CMD_UNLOCK, 1'b0);
    simple(sec_pkg::CMD_ERASE, 1'b1);
  endtask

  task automatic t_erase_ok;
    erase(16'h0001, 16'hA000, 0, 1'b0);
    erase(16'h0000, 16'h9999, 3, 1'b0);
    cmd(8'hF1, 1'b1, 16'h0000, 16'hC000, 16'h0000, 0, 1'b0);
    chk("lock_enabled", 28'h1, 28'(lock_enabled));
    chk("level_max", 28'h0, 28'(level_max));
  endtask

  task automatic t_freeze;
    logic [7:0] codes[4] = '{8'hF1, 8'hF2, 8'hF6, 8'hEE};
    simple(sec_pkg::CMD_FREEZE, 1'b0);
    chk("frozen", 28'h1, 28'(frozen));
    foreach (codes[k])
      simple(codes[k], 1'b1);
    simple(sec_pkg::CMD_ERASE_PREP, 1'b0);
    simple(sec_pkg::CMD_ERASE, 1'b1);
    pulse_hard_reset();
    chk("frozen", 28'h1, 28'(frozen));
  endtask

  task automatic t_power_cycle;
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk("frozen", 28'h0, 28'(frozen));
    chk("lock_enabled", 28'h1, 28'(lock_enabled));
    chk("rev_code", 28'h1234, 28'(rev_code));
    chk("locked", 28'h1, 28'(locked));
    erase(16'h0001, 16'hA000, 0, 1'b0);
  endtask

  initial begin
    rst = 1'b1;
    hard_reset = 1'b0;
    nv_format = 1'b1;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    nv_format = 1'b0;
    chk("lock_enabled", 28'h0, 28'(lock_enabled));
    t_set_master();
    t_set_user_max();
    t_erase_refused();
    t_erase_ok();
    t_freeze();
    t_power_cycle();
    final_report();
  end
endmodule
